//--- core/levin_pkg.sv
// constants and types shared by both ends of the latched event input link
package levin_pkg;
    localparam int          LEVIN_CHANNELS        = 16;
    localparam int          LEVIN_CLK_HZ          = 40000000;
    // minimum qualified pulse width, microseconds
    localparam int          LEVIN_MIN_PULSE_US    = 500;
    localparam int          LEVIN_MIN_PULSE_CYC   =
        (LEVIN_MIN_PULSE_US * (LEVIN_CLK_HZ / 1000000) + 0) > 0 ?
        LEVIN_MIN_PULSE_US * (LEVIN_CLK_HZ / 1000000) : 1;
    // scan time limits, milliseconds
    localparam int          LEVIN_SCAN_SW_MS      = 200;
    localparam int          LEVIN_SCAN_HW_MS      = 250;
    localparam int          LEVIN_SCAN_HW_CYC     = LEVIN_SCAN_HW_MS * (LEVIN_CLK_HZ / 1000);
    // default controller scan period, cycles (shortenable parameter)
    localparam int          LEVIN_SCAN_DFLT_CYC   = 4000;
    localparam logic [15:0] LEVIN_WORD_RESET      = 16'h0000;
    localparam logic [4:0]  LEVIN_CNT_ZERO        = 5'h00;

    // mapping of event bits towards the controller
    typedef enum logic [0:0] {
        LEVIN_MAP_BIT  = 1'b0,
        LEVIN_MAP_WORD = 1'b1
    } levin_map_t;

    typedef enum logic [1:0] {
        LEVIN_ST_IDLE  = 2'b00,
        LEVIN_ST_SHIFT = 2'b01,
        LEVIN_ST_DONE  = 2'b10
    } levin_st_t;
endpackage

//--- core/levin_link_if.sv
// serial link between the event input module and the scanning controller
`timescale 1ns/10ps
interface levin_link_if;
    logic scan_start;
    logic shift_en;
    logic event_sd;
    logic echo_sd;
    logic scan_done;

    modport device (
        input  scan_start,
        input  shift_en,
        output event_sd,
        input  echo_sd,
        input  scan_done
    );
    modport host (
        output scan_start,
        output shift_en,
        input  event_sd,
        output echo_sd,
        output scan_done
    );
endinterface

//--- core/levin_device.sv
// latched event input module: qualify, latch, report and echo-clear 16 channels
`timescale 1ns/10ps
module levin_device
    import levin_pkg::*;
#(
    parameter int N_CH      = LEVIN_CHANNELS,
    parameter int PULSE_CYC = LEVIN_MIN_PULSE_CYC
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // field side: unqualified on bits from the comparators
    input  wire logic [N_CH-1:0]  field_event_bit,
    // configuration
    input  wire logic             map_word,
    // controller link
    levin_link_if.device          link,
    // status view
    output logic [N_CH-1:0]       latch_state,
    output logic [N_CH-1:0]       report_word,
    output logic                  report_is_word
);
    localparam int CW = $clog2(PULSE_CYC + 1);
    localparam int SW = $clog2(N_CH + 1);

    logic [N_CH-1:0] latch_r;
    logic [N_CH-1:0] out_sh_r;
    logic [N_CH-1:0] in_sh_r;
    logic [N_CH-1:0] report_r;
    logic            map_r;
    logic [SW-1:0]   bit_cnt_r;
    logic            echo_valid_r;
    logic            map_s1_r;
    logic            map_s2_r;
    levin_st_t       fr_r;
    levin_st_t       fr_nxt;
    logic [N_CH-1:0] out_sh_nxt;
    logic [N_CH-1:0] in_sh_nxt;
    logic [N_CH-1:0] report_nxt;
    logic            map_nxt;
    logic [SW-1:0]   bit_cnt_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // per channel qualification and latch
    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            logic          s1_r;
            logic          s2_r;
            logic [CW-1:0] wid_r;
            logic          qual_r;
            logic          qual_d_r;
            wire           wid_full = (wid_r >= CW'(PULSE_CYC));
            wire           rise     = qual_r & ~qual_d_r;
            // echo returns the reported state inverted: a 0 acknowledges a set latch
            wire           ack      = echo_valid_r & ~in_sh_r[g];
            wire           set_w    = rise & ~latch_r[g];
            wire           clr_w    = ack & report_r[g];

            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset) begin
                    s1_r     <= 1'b0;
                    s2_r     <= 1'b0;
                    wid_r    <= '0;
                    qual_r   <= 1'b0;
                    qual_d_r <= 1'b0;
                end else begin
                    s1_r     <= field_event_bit[g];
                    s2_r     <= s1_r;
                    if (!s2_r)
                        wid_r <= '0;
                    else if (!wid_full)
                        wid_r <= wid_r + CW'(1);
                    qual_r   <= s2_r & wid_full;
                    qual_d_r <= qual_r;
                end
            end

            // set wins over clear; set latch ignores edges until cleared
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset)
                    latch_r[g] <= 1'b0;
                else if (set_w)
                    latch_r[g] <= 1'b1;
                else if (clr_w)
                    latch_r[g] <= 1'b0;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // configuration strap comes from a pin: two flops before the snapshot reads it
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            map_s1_r <= LEVIN_MAP_BIT;
            map_s2_r <= LEVIN_MAP_BIT;
        end else begin
            map_s1_r <= map_word;
            map_s2_r <= map_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame sequencer: snapshot at scan start, count shifts, take echo at done
    wire start_w  = link.scan_start;
    wire shift_w  = link.shift_en;
    wire done_w   = link.scan_done;
    // the counter rests at N_CH while the frame waits for done
    wire last_w   = (bit_cnt_r == SW'(N_CH - 1));
    wire in_fr_w  = (fr_r == LEVIN_ST_SHIFT);
    wire full_w   = (fr_r == LEVIN_ST_DONE);

    // a restart wins over a shift in the same cycle
    wire shift_go = shift_w & ~start_w & in_fr_w;
    // a cut or overlong frame clears nothing: its echo cannot be trusted
    wire echo_ok  = done_w & ~start_w & ~shift_w & full_w;

    always_comb begin
        fr_nxt = fr_r;
        case (fr_r)
            LEVIN_ST_IDLE: begin
                if (start_w)
                    fr_nxt = LEVIN_ST_SHIFT;
            end
            LEVIN_ST_SHIFT: begin
                if (start_w)
                    fr_nxt = LEVIN_ST_SHIFT;
                else if (shift_w && last_w)
                    fr_nxt = LEVIN_ST_DONE;
                else if (done_w)
                    fr_nxt = LEVIN_ST_IDLE;
            end
            LEVIN_ST_DONE: begin
                if (start_w)
                    fr_nxt = LEVIN_ST_SHIFT;
                else if (shift_w || done_w)
                    fr_nxt = LEVIN_ST_IDLE;
            end
            default: begin
                fr_nxt = LEVIN_ST_IDLE;
            end
        endcase
    end

    // only latch states leave on the link, and only through the snapshot
    assign out_sh_nxt  = start_w  ? latch_r :
                         shift_go ? {1'b0, out_sh_r[N_CH-1:1]} :
                         out_sh_r;
    assign in_sh_nxt   = shift_go ? {link.echo_sd, in_sh_r[N_CH-1:1]} :
                         in_sh_r;
    assign report_nxt  = start_w  ? latch_r :
                         report_r;
    assign map_nxt     = start_w  ? map_s2_r :
                         map_r;
    assign bit_cnt_nxt = start_w  ? SW'(0) :
                         shift_go ? bit_cnt_r + SW'(1) :
                         bit_cnt_r;

    // frame control
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            fr_r         <= LEVIN_ST_IDLE;
            bit_cnt_r    <= '0;
            echo_valid_r <= 1'b0;
        end else begin
            fr_r         <= fr_nxt;
            bit_cnt_r    <= bit_cnt_nxt;
            echo_valid_r <= echo_ok;
        end
    end

    // shift data and the captured view of the last frame
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            out_sh_r <= LEVIN_WORD_RESET;
            in_sh_r  <= LEVIN_WORD_RESET;
            report_r <= LEVIN_WORD_RESET;
            map_r    <= LEVIN_MAP_BIT;
        end else begin
            out_sh_r <= out_sh_nxt;
            in_sh_r  <= in_sh_nxt;
            report_r <= report_nxt;
            map_r    <= map_nxt;
        end
    end

    // link and status outputs all come straight from flops
    assign link.event_sd  = out_sh_r[0];
    assign latch_state    = latch_r;
    assign report_word    = report_r;
    assign report_is_word = map_r;
endmodule // levin_device

//--- core/levin_host.sv
// controller end: scans event bits and echoes them back inverted
`timescale 1ns/10ps
module levin_host
    import levin_pkg::*;
#(
    parameter int N_CH     = LEVIN_CHANNELS,
    parameter int SCAN_CYC = LEVIN_SCAN_DFLT_CYC
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset,
    // controller side
    input  wire logic             scan_en,
    output logic [N_CH-1:0]       event_word,
    output logic                  event_valid,
    // controller link
    levin_link_if.host            link
);
    localparam int SW = $clog2(N_CH + 1);
    localparam int PW = $clog2(SCAN_CYC + 1);

    levin_st_t        st_r;
    levin_st_t        st_nxt;
    logic [PW-1:0]    per_r;
    logic [SW-1:0]    cnt_r;
    logic [N_CH-1:0]  rx_r;
    logic [N_CH-1:0]  echo_r;
    logic [N_CH-1:0]  word_r;
    logic             valid_r;

    // scan period kept well inside the software and hardware limits
    wire tick     = (per_r == '0);
    wire last_bit = (cnt_r == SW'(N_CH - 1));

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            LEVIN_ST_IDLE:  if (tick && scan_en) st_nxt = LEVIN_ST_SHIFT;
            LEVIN_ST_SHIFT: if (last_bit) st_nxt = LEVIN_ST_DONE;
            LEVIN_ST_DONE:  st_nxt = LEVIN_ST_IDLE;
            default:        st_nxt = LEVIN_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_r    <= LEVIN_ST_IDLE;
            per_r   <= '0;
            cnt_r   <= '0;
            rx_r    <= LEVIN_WORD_RESET;
            // nothing is acknowledged before a frame has been received
            echo_r  <= ~LEVIN_WORD_RESET;
            word_r  <= LEVIN_WORD_RESET;
            valid_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            valid_r <= 1'b0;
            per_r   <= tick ? PW'(SCAN_CYC - 1) : per_r - PW'(1);
            case (st_r)
                LEVIN_ST_IDLE:  cnt_r <= '0;
                LEVIN_ST_SHIFT: begin
                    rx_r   <= {link.event_sd, rx_r[N_CH-1:1]};
                    // echo last scan's events inverted: acknowledges what was received
                    echo_r <= {1'b0, echo_r[N_CH-1:1]};
                    cnt_r  <= cnt_r + SW'(1);
                end
                LEVIN_ST_DONE: begin
                    word_r  <= rx_r;
                    valid_r <= 1'b1;
                    echo_r  <= ~rx_r;
                end
                default: cnt_r <= '0;
            endcase
        end
    end

    // sample on the cycle after start so device snapshot is loaded
    assign link.scan_start = (st_r == LEVIN_ST_IDLE) && tick && scan_en;
    assign link.shift_en   = (st_r == LEVIN_ST_SHIFT);
    assign link.echo_sd    = echo_r[0];
    assign link.scan_done  = (st_r == LEVIN_ST_DONE);
    assign event_word      = word_r;
    assign event_valid     = valid_r;
endmodule // levin_host

//--- sim/levin_assertions.sv
// link protocol checks between the two ends
`timescale 1ns/10ps
module levin_assertions (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // link signals
    input wire logic scan_start,
    input wire logic shift_en,
    input wire logic event_sd,
    input wire logic echo_sd,
    input wire logic scan_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////
    sequence shift16_s;
        shift_en[*8] ##1 shift_en[*8];
    endsequence
    sequence close_s;
        !shift_en && scan_done;
    endsequence
    frame_len_a: assert property (scan_start |=> shift16_s ##1 close_s)
        else $error("frame length wrong");
    done_pulse_a: assert property (scan_done |=> !scan_done)
        else $error("done too long");
    done_idle_a: assert property (scan_done |-> !shift_en && !scan_start)
        else $error("done overlaps");
    start_gap_a: assert property (scan_start |=> !scan_start[*8] ##1 !scan_start[*8])
        else $error("scans too close");
    shift_cause_a: assert property ($rose(shift_en) |-> $past(scan_start))
        else $error("shift without start");
    done_cause_a: assert property (scan_done |-> $past(shift_en))
        else $error("done without shift");
    shift_alone_a: assert property (shift_en |-> !scan_start)
        else $error("start inside frame");
    // the report line may only move when a frame loads or shifts it
    sd_hold_a: assert property (!$stable(event_sd) |-> $past(shift_en) || $past(scan_start))
        else $error("report line moved");
endmodule // levin_assertions

//--- sim/levin_test.sv
// self-checking bench for both link ends
`timescale 1ns/10ps
module levin_test;
    import levin_pkg::*;
    localparam int PW = 8;
    localparam int SC = 40;
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] field_event_bit = 16'h0000;
    logic        map_word = 1'b0;
    logic        scan_en = 1'b0;
    logic [15:0] latch_state;
    logic [15:0] report_word;
    logic [15:0] event_word;
    logic        report_is_word;
    logic        event_valid;
    logic [31:0] seed = 32'hF5119BD7;
    int          miscompares = 0;
    int          n_checks = 0;
    levin_link_if link ();
    levin_device #(.N_CH(16), .PULSE_CYC(PW)) levin_device_inst (.sys_clk(sys_clk),
        .reset(reset), .field_event_bit(field_event_bit), .map_word(map_word), .link(link),
        .latch_state(latch_state), .report_word(report_word), .report_is_word(report_is_word));
    levin_host #(.N_CH(16), .SCAN_CYC(SC)) levin_host_inst (.sys_clk(sys_clk), .reset(reset),
        .scan_en(scan_en), .event_word(event_word), .event_valid(event_valid), .link(link));
    levin_assertions levin_assertions_inst (.sys_clk(sys_clk), .reset(reset),
        .scan_start(link.scan_start), .shift_en(link.shift_en), .event_sd(link.event_sd),
        .echo_sd(link.echo_sd), .scan_done(link.scan_done));
    always #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic timeout(input int k, input int lim);
        if (k >= lim) begin
            miscompares++;
            $display("mismatch wait expected done seen timeout");
            end_sim();
        end
    endtask
    ////////////////////////////////////////
    initial begin
        logic [15:0] m;
        int          k;
        cyc(6);
        reset = 1'b0;
        chk("latch", 16'h0000, latch_state);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            m = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h8001 : (seed[15:0] | 16'h0001);
            map_word = seed[16];
            // too brief to count on the other channels
            field_event_bit = ~m;
            cyc(PW - 4);
            field_event_bit = 16'h0000;
            cyc(4);
            field_event_bit = m;
            for (k = 0; k < 30 && latch_state !== m; k++) cyc(1);
            timeout(k, 30);
            chk("latch", m, latch_state);
            // first pass: the very first frame after reset finds an event already latched
            scan_en = 1'b1;
            // a fresh rise while latched must leave nothing pending
            field_event_bit = 16'h0000;
            cyc(2);
            field_event_bit = m;
            for (k = 0; k < 4*SC && !(event_valid === 1'b1 && event_word !== 16'h0000); k++)
                cyc(1);
            timeout(k, 4*SC);
            chk("event_word", m, event_word);
            chk("map", {15'h0000, map_word}, {15'h0000, report_is_word});
            chk("report", m, report_word);
            // one report alone must not clear: the echo of that report comes a frame later
            cyc(2);
            chk("held", m, latch_state);
            for (k = 0; k < 4*SC && latch_state !== 16'h0000; k++) cyc(1);
            timeout(k, 4*SC);
            cyc(PW + 6);
            chk("rearm", 16'h0000, latch_state);
            field_event_bit = 16'h0000;
            cyc(SC);
        end
        end_sim();
    end
endmodule // levin_test
